/* File: sampling_clock_regs.vh */
/*
 * Constants for the sampling clock source and phase control block:
 * clock figures, phase code limits, switch-over timing and state codes.
 * Assumes it is included by bare name from the design files.
 */
`ifndef SAMPLING_CLOCK_REGS_VH
`define SAMPLING_CLOCK_REGS_VH

// ----------------------------------------------------------------------
// Clock figures
// ----------------------------------------------------------------------
`define SYS_CLK_PERIOD_NS   8
`define NCO_WIDTH           24
// 53.10366 MHz / 125 MHz scaled by 2^24, rounded to nearest
`define NCO_INCREMENT       24'h6cc19d

// ----------------------------------------------------------------------
// Phase and time-of-flight codes
// ----------------------------------------------------------------------
`define PHASE_WIDTH         5
// One sampling period is 18.83 ns, so 1 ns steps run 0..18
`define PHASE_MAX           5'h12
`define TOF_WIDTH           3
`define TOF_DEPTH           8

// ----------------------------------------------------------------------
// Switch-over timing
// ----------------------------------------------------------------------
`define MUTE_NS             64
`define SETTLE_NS           200
`define MUTE_CYC   ((`MUTE_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define SETTLE_CYC ((`SETTLE_NS + `SYS_CLK_PERIOD_NS - 1) / `SYS_CLK_PERIOD_NS)
`define WAIT_WIDTH          6
// Down-counter loads, one less than the cycle counts above, at counter width
`define MUTE_LOAD           6'h07
`define SETTLE_LOAD         6'h18

// ----------------------------------------------------------------------
// Switch-over state codes
// ----------------------------------------------------------------------
`define ST_RUN              2'h0
`define ST_MUTE             2'h1
`define ST_APPLY            2'h2
`define ST_SETTLE           2'h3

`endif

/* File: crate_fanout.v */
/*
 * One front-end crate output: holds the applied phase code for its
 * delay line and delays the gate and clear signals by 0..7 sampling
 * periods. Assumes tick pulses once per sampling period and apply pulses
 * only while the outputs are muted.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sampling_clock_regs.vh"

module crate_fanout (
    // Clock and reset
    input  wire                      sys_clk,
    input  wire                      resetn,
    // Control from the top
    input  wire                      tick,
    input  wire                      apply,
    input  wire [`PHASE_WIDTH-1:0]   phase_req,
    input  wire [`TOF_WIDTH-1:0]     tof_req,
    // Signals to delay
    input  wire                      gate_in,
    input  wire                      clear_in,
    // Outputs
    output reg  [`PHASE_WIDTH-1:0]   phase_code_r,
    output reg                       gate_out_r,
    output reg                       clear_out_r
);

    reg [`TOF_WIDTH-1:0]   tof_r;
    reg [`TOF_DEPTH-1:0]   gate_sr_r;
    reg [`TOF_DEPTH-1:0]   clear_sr_r;

    // ------------------------------------------------------------------
    // Settings take effect only on apply, never mid-run
    // ------------------------------------------------------------------
    // per-crate phase
    always @(posedge sys_clk) begin
        if (!resetn) begin
            phase_code_r <= {`PHASE_WIDTH{1'b0}};
            tof_r        <= {`TOF_WIDTH{1'b0}};
        end else if (apply) begin
            // Clamp to one period so the delay line never wraps
            phase_code_r <= (phase_req > `PHASE_MAX) ? `PHASE_MAX : phase_req;
            tof_r        <= tof_req;
        end
    end

    // ------------------------------------------------------------------
    // Delay chains advance once per sampling period
    // ------------------------------------------------------------------
    // whole-period delay
    always @(posedge sys_clk) begin
        if (!resetn) begin
            gate_sr_r   <= {`TOF_DEPTH{1'b0}};
            clear_sr_r  <= {`TOF_DEPTH{1'b0}};
            gate_out_r  <= 1'b0;
            clear_out_r <= 1'b0;
        end else begin
            if (tick) begin
                gate_sr_r  <= {gate_sr_r[`TOF_DEPTH-2:0], gate_in};
                clear_sr_r <= {clear_sr_r[`TOF_DEPTH-2:0], clear_in};
            end
            gate_out_r  <= gate_sr_r[tof_r];
            clear_out_r <= clear_sr_r[tof_r];
        end
    end

endmodule // crate_fanout

`default_nettype wire

/* File: sampling_clock_source.v */
/*
 * Sampling clock source and phase control. Chooses between the RF
 * reference and the free-running local oscillator, sets the global and
 * per-crate delay line codes, and times the gate and clear outputs of
 * each crate in whole sampling periods. Assumes external delay lines,
 * an external clock mux and output gates driven by the codes and enables
 * below; all control inputs come from pins outside sys_clk.
 */
`timescale 1ns/10ps
`default_nettype none
`include "sampling_clock_regs.vh"

module sampling_clock_source #(
    parameter NUM_CRATES = 4
) (
    // Clock and reset
    input  wire                                 sys_clk,
    input  wire                                 resetn,
    // Settings from pins
    input  wire                                 use_local_osc,
    input  wire [`PHASE_WIDTH-1:0]              global_phase_req,
    input  wire [NUM_CRATES*`PHASE_WIDTH-1:0]   crate_phase_req,
    input  wire [NUM_CRATES*`TOF_WIDTH-1:0]     crate_tof_req,
    // Accelerator derived signals
    input  wire                                 beam_window_gate,
    input  wire                                 timestamp_counter_clear,
    // Clock path control
    output reg                                  clk_mux_sel_r,
    output reg  [`PHASE_WIDTH-1:0]              global_delay_code_r,
    output reg                                  fanout_enable_r,
    output reg                                  readout_clk_enable_r,
    output reg                                  sampling_tick_r,
    // Per-crate outputs
    output wire [NUM_CRATES*`PHASE_WIDTH-1:0]   crate_delay_code,
    output wire [NUM_CRATES-1:0]                crate_gate,
    output wire [NUM_CRATES-1:0]                crate_clear
);

    localparam SETW = 1 + `PHASE_WIDTH + NUM_CRATES * (`PHASE_WIDTH + `TOF_WIDTH);

    // ------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------
    reg [SETW-1:0]  set_meta_r;
    reg [SETW-1:0]  set_sync_r;
    reg [1:0]       sig_meta_r;
    reg [1:0]       sig_sync_r;
    wire [SETW-1:0] set_pins;

    assign set_pins = {use_local_osc, global_phase_req, crate_phase_req, crate_tof_req};

    // Two stages before any logic looks at a pin
    always @(posedge sys_clk) begin
        if (!resetn) begin
            set_meta_r <= {SETW{1'b0}};
            set_sync_r <= {SETW{1'b0}};
            sig_meta_r <= 2'h0;
            sig_sync_r <= 2'h0;
        end else begin
            set_meta_r <= set_pins;
            set_sync_r <= set_meta_r;
            sig_meta_r <= {beam_window_gate, timestamp_counter_clear};
            sig_sync_r <= sig_meta_r;
        end
    end

    // ------------------------------------------------------------------
    // Sampling period tick
    // ------------------------------------------------------------------
    // Phase accumulator paces the per-period delay chains at the
    // nominal rate; jitter is one sys_clk, which is well inside the
    // one-period cable timing budget of the gate and clear lines.
    reg [`NCO_WIDTH-1:0]  nco_r;
    wire [`NCO_WIDTH:0]   nco_sum;

    assign nco_sum = {1'b0, nco_r} + {1'b0, `NCO_INCREMENT};

    always @(posedge sys_clk) begin
        if (!resetn) begin
            nco_r           <= {`NCO_WIDTH{1'b0}};
            sampling_tick_r <= 1'b0;
        end else begin
            nco_r           <= nco_sum[`NCO_WIDTH-1:0];
            sampling_tick_r <= nco_sum[`NCO_WIDTH];
        end
    end

    // ------------------------------------------------------------------
    // Applied settings and change detect
    // ------------------------------------------------------------------
    reg [SETW-1:0]  applied_r;
    reg [SETW-1:0]  pending_r;
    wire            settings_differ;

    assign settings_differ = (set_sync_r != applied_r);

    // ------------------------------------------------------------------
    // Switch-over sequencer
    // ------------------------------------------------------------------
    reg [1:0]             state_r;
    reg [1:0]             state_nxt;
    reg [`WAIT_WIDTH-1:0] wait_r;
    reg [`WAIT_WIDTH-1:0] wait_nxt;
    reg                   apply_nxt;
    reg                   apply_r;

    // Mute, change, settle, unmute: the output gates close on a quiet
    // clock, so switching the mux or delay lines cannot leak a runt.
    // glitch-free changes
    always @* begin
        state_nxt = state_r;
        wait_nxt  = wait_r;
        apply_nxt = 1'b0;
        case (state_r)
            `ST_RUN: begin
                if (settings_differ) begin
                    state_nxt = `ST_MUTE;
                    wait_nxt  = `MUTE_LOAD;
                end
            end
            `ST_MUTE: begin
                if (wait_r == {`WAIT_WIDTH{1'b0}}) begin
                    state_nxt = `ST_APPLY;
                    apply_nxt = 1'b1;
                end else begin
                    wait_nxt = wait_r - 1'b1;
                end
            end
            `ST_APPLY: begin
                state_nxt = `ST_SETTLE;
                wait_nxt  = `SETTLE_LOAD;
            end
            `ST_SETTLE: begin
                if (wait_r == {`WAIT_WIDTH{1'b0}}) begin
                    if (settings_differ) begin
                        // A setting moved during the round: stay muted rather
                        // than open the gates for one short cycle
                        state_nxt = `ST_MUTE;
                        wait_nxt  = `MUTE_LOAD;
                    end else begin
                        state_nxt = `ST_RUN;
                    end
                end else begin
                    wait_nxt = wait_r - 1'b1;
                end
            end
            default: begin
                state_nxt = `ST_RUN;
                wait_nxt  = {`WAIT_WIDTH{1'b0}};
            end
        endcase
    end

    // Sequencer registers; the snapshot is taken on entry to mute so
    // that a setting still moving during the mute is caught next round
    always @(posedge sys_clk) begin
        if (!resetn) begin
            state_r   <= `ST_MUTE;
            wait_r    <= `MUTE_LOAD;
            apply_r   <= 1'b0;
            pending_r <= {SETW{1'b0}};
        end else begin
            state_r <= state_nxt;
            wait_r  <= wait_nxt;
            apply_r <= apply_nxt;
            if (state_nxt == `ST_MUTE && state_r != `ST_MUTE) begin
                pending_r <= set_sync_r;
            end
        end
    end

    // ------------------------------------------------------------------
    // Clock path control outputs
    // ------------------------------------------------------------------
    // Gates stay shut from reset until the first settle ends
    // source select
    always @(posedge sys_clk) begin
        if (!resetn) begin
            applied_r            <= {SETW{1'b0}};
            clk_mux_sel_r        <= 1'b0;
            global_delay_code_r  <= {`PHASE_WIDTH{1'b0}};
            fanout_enable_r      <= 1'b0;
            readout_clk_enable_r <= 1'b0;
        end else begin
            if (apply_nxt) begin
                applied_r     <= pending_r;
                clk_mux_sel_r <= pending_r[SETW-1];
                if (pending_r[SETW-2 -: `PHASE_WIDTH] > `PHASE_MAX) begin
                    global_delay_code_r <= `PHASE_MAX;
                end else begin
                    global_delay_code_r <= pending_r[SETW-2 -: `PHASE_WIDTH];
                end
            end
            fanout_enable_r      <= (state_nxt == `ST_RUN);
            readout_clk_enable_r <= (state_nxt == `ST_RUN);
        end
    end

    // ------------------------------------------------------------------
    // Per-crate fan-out
    // ------------------------------------------------------------------
    // one delay per crate
    genvar g;
    generate
        for (g = 0; g < NUM_CRATES; g = g + 1) begin : crate
            crate_fanout u_fanout (
                .sys_clk      (sys_clk),
                .resetn       (resetn),
                .tick         (sampling_tick_r),
                .apply        (apply_r),
                .phase_req    (applied_r[NUM_CRATES*`TOF_WIDTH + g*`PHASE_WIDTH
                                         +: `PHASE_WIDTH]),
                .tof_req      (applied_r[g*`TOF_WIDTH +: `TOF_WIDTH]),
                .gate_in      (sig_sync_r[1]),
                .clear_in     (sig_sync_r[0]),
                .phase_code_r (crate_delay_code[g*`PHASE_WIDTH +: `PHASE_WIDTH]),
                .gate_out_r   (crate_gate[g]),
                .clear_out_r  (crate_clear[g])
            );
        end
    endgenerate

endmodule // sampling_clock_source

`default_nettype wire

/* File: sampling_clock_properties.sv */
/* Port checker for sampling_clock_source.
   Assumes it is bound into every instance of the top module. */
`timescale 1ns/10ps
`default_nettype none
`include "sampling_clock_regs.vh"
module sampling_clock_checker #(
    parameter NUM_CRATES = 4
) (
    // Clock and reset
    input wire                               sys_clk,
    input wire                               resetn,
    // Pins
    input wire                               use_local_osc,
    input wire [`PHASE_WIDTH-1:0]            global_phase_req,
    // Outputs
    input wire                               clk_mux_sel_r,
    input wire [`PHASE_WIDTH-1:0]            global_delay_code_r,
    input wire                               fanout_enable_r,
    input wire                               readout_clk_enable_r,
    input wire                               sampling_tick_r,
    input wire [NUM_CRATES*`PHASE_WIDTH-1:0] crate_delay_code
);
    // ------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!resetn);
    a_mux_when_muted: assert property ($changed(clk_mux_sel_r) |-> !fanout_enable_r)
        else $error("mux changed with outputs live");
    a_code_when_muted: assert property ($changed(global_delay_code_r) |-> !fanout_enable_r)
        else $error("global code changed with outputs live");
    a_crate_when_muted: assert property ($changed(crate_delay_code) |-> !fanout_enable_r)
        else $error("crate code changed with outputs live");
    a_enables_paired: assert property (fanout_enable_r == readout_clk_enable_r)
        else $error("readout and front-end enables differ");
    a_global_clamped: assert property (global_delay_code_r <= `PHASE_MAX)
        else $error("global code above one period");
    a_tick_single: assert property (sampling_tick_r |=> !sampling_tick_r)
        else $error("two ticks in a row");
    // tick spacing gives the sampling rate
    a_tick_period: assert property ($rose(sampling_tick_r) |-> ##[2:3] sampling_tick_r)
        else $error("tick spacing wrong");
    // a new source or global phase setting mutes the outputs first
    a_change_mutes: assert property (($changed(use_local_osc) || $changed(global_phase_req))
        && fanout_enable_r |-> ##[1:4] !fanout_enable_r)
        else $error("setting change did not mute outputs");
    a_reset_quiet: assert property (disable iff (1'b0) !resetn |=> !fanout_enable_r && !clk_mux_sel_r)
        else $error("outputs live after reset");
    // each crate code within one period
    genvar g;
    for (g = 0; g < NUM_CRATES; g = g + 1) begin : g_chk
        a_crate_clamped: assert property (crate_delay_code[g*`PHASE_WIDTH +: `PHASE_WIDTH] <= `PHASE_MAX)
            else $error("crate code above one period");
    end
endmodule // sampling_clock_checker
bind sampling_clock_source sampling_clock_checker #(.NUM_CRATES(NUM_CRATES)) chk_u (
    .sys_clk(sys_clk), .resetn(resetn), .use_local_osc(use_local_osc),
    .global_phase_req(global_phase_req), .clk_mux_sel_r(clk_mux_sel_r),
    .global_delay_code_r(global_delay_code_r), .fanout_enable_r(fanout_enable_r),
    .readout_clk_enable_r(readout_clk_enable_r), .sampling_tick_r(sampling_tick_r),
    .crate_delay_code(crate_delay_code));
`default_nettype wire

/* File: crate_card_model.sv */
/* Model of one front-end crate timing card.
   Assumes tick marks each sampling period of the block. */
`timescale 1ns/10ps
`default_nettype none
module crate_card_model (
    // Clock and reset
    input  wire       sys_clk,
    input  wire       resetn,
    // From the clock source
    input  wire       tick,
    input  wire       gate_in,
    input  wire       clear_in,
    // To the motherboards
    output logic      half_clk_r,
    output wire       board_gate,
    output wire       board_clear
);
    assign board_gate  = gate_in;
    assign board_clear = clear_in;
    // transfer clock at half the sampling rate
    always @(posedge sys_clk) begin
        if (!resetn) begin
            half_clk_r <= 1'b0;
        end else if (tick) begin
            half_clk_r <= ~half_clk_r;
        end
    end
endmodule // crate_card_model
`default_nettype wire

/* File: sampling_clock_source_test.sv */
/* Self-checking bench for sampling_clock_source.
   Assumes the crate card model and the bound port checker. */
`timescale 1ns/10ps
`default_nettype none
`include "sampling_clock_regs.vh"
module sampling_clock_source_test;
    typedef struct packed {logic osc; logic [4:0] gp; logic [4:0] cp;
        logic [4:0] eg; logic [19:0] ec;} row_t;
    reg         sys_clk = 1'b0;
    reg         resetn = 1'b0;
    reg         use_local_osc = 1'b0;
    reg  [4:0]  global_phase_req = 5'h00;
    reg  [19:0] crate_phase_req = 20'h00000;
    reg  [11:0] crate_tof_req = 12'hf58;
    reg         beam_window_gate = 1'b0;
    reg         timestamp_counter_clear = 1'b0;
    wire        mux, en, ren, tick, half, bgate, bclear;
    wire [4:0]  gcode;
    wire [19:0] ccode;
    wire [3:0]  cgate, cclear;
    wire [3:0]  gate_v = {cgate[3:1], bgate};
    wire [3:0]  clear_v = {cclear[3:1], bclear};
    integer     fails = 0, checked = 0, tick_cnt = 0, r, g, k;
    integer     t_at [0:7];
    reg  [7:0]  seen;
    // Inputs, then expected global code and packed crate codes (crate g at 5g)
    row_t rows [0:4] = '{'{1'b1, 5'h05, 5'h03, 5'h05, 20'h31483},
        '{1'b0, 5'h12, 5'h10, 5'h12, 20'h94a30}, '{1'b1, 5'h1f, 5'h00, 5'h12, 20'h18820},
        '{1'b0, 5'h00, 5'h1c, 5'h00, 20'h94a52}, '{1'b0, 5'h01, 5'h01, 5'h01, 20'h20c41}};
    sampling_clock_source dut_u (.sys_clk(sys_clk), .resetn(resetn),
        .use_local_osc(use_local_osc), .global_phase_req(global_phase_req),
        .crate_phase_req(crate_phase_req), .crate_tof_req(crate_tof_req),
        .beam_window_gate(beam_window_gate), .timestamp_counter_clear(timestamp_counter_clear),
        .clk_mux_sel_r(mux), .global_delay_code_r(gcode), .fanout_enable_r(en),
        .readout_clk_enable_r(ren), .sampling_tick_r(tick), .crate_delay_code(ccode),
        .crate_gate(cgate), .crate_clear(cclear));
    crate_card_model card_u (.sys_clk(sys_clk), .resetn(resetn), .tick(tick),
        .gate_in(cgate[0]), .clear_in(cclear[0]), .half_clk_r(half),
        .board_gate(bgate), .board_clear(bclear));
    // 125 MHz clock
    always #4 sys_clk = ~sys_clk;
    // Count sampling periods for delay checks
    always @(posedge sys_clk) if (tick === 1'b1) tick_cnt <= tick_cnt + 1;
    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    task check(input logic [31:0] got, input logic [31:0] exp);
        checked = checked + 1;
        if (got !== exp) begin
            fails = fails + 1;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // Wait until outputs run steadily; a change mid-wait restarts the count
    task wait_run;
        integer n, w;
        n = 0;
        w = 0;
        while (n < 8 && w < 400) begin
            @(negedge sys_clk);
            w = w + 1;
            n = (en === 1'b1) ? n + 1 : 0;
        end
        check(n, 32'd8);
    endtask
    task stop_test;
        if (fails == 0 && checked > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    // Hang guard, several times the expected run
    initial begin
        #40000;
        fails = fails + 1;
        stop_test;
    end
    // ------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------
    initial begin
        repeat (10) @(posedge sys_clk);
        // quiet in reset, looked at once settled
        @(negedge sys_clk);
        check({en, mux, cgate}, 32'h0);
        repeat (2) @(posedge sys_clk);
        resetn <= 1'b1;
        wait_run;
        for (r = 0; r < 5; r = r + 1) begin
            @(posedge sys_clk);
            use_local_osc <= rows[r].osc;
            global_phase_req <= rows[r].gp;
            for (g = 0; g < 4; g = g + 1) crate_phase_req[g*5 +: 5] <= rows[r].cp + 5'(g);
            wait_run;
            check(mux, rows[r].osc);
            check(gcode, rows[r].eg);
            for (g = 0; g < 4; g = g + 1) check(ccode[g*5 +: 5], rows[r].ec[g*5 +: 5]);
            check(ren, 1'b1);
        end
        // change inside mute is caught afterwards
        @(posedge sys_clk);
        global_phase_req <= 5'h03;
        use_local_osc <= 1'b1;
        repeat (6) @(posedge sys_clk);
        global_phase_req <= 5'h09;
        wait_run;
        check(gcode, 5'h09);
        // gate and clear delayed by whole periods
        @(posedge sys_clk);
        beam_window_gate <= 1'b1;
        timestamp_counter_clear <= 1'b1;
        seen = 8'h00;
        for (k = 0; k < 200 && seen != 8'hff; k = k + 1) begin
            @(negedge sys_clk);
            for (g = 0; g < 8; g = g + 1) begin
                if (!seen[g] && ((g < 4) ? gate_v[g & 3] : clear_v[g & 3]) === 1'b1) begin
                    seen[g] = 1'b1;
                    t_at[g] = tick_cnt;
                end
            end
        end
        check(seen, 8'hff);
        for (g = 1; g < 4; g = g + 1) begin
            check(t_at[g] - t_at[0], crate_tof_req[g*3 +: 3]);
            check(t_at[g+4] - t_at[4], crate_tof_req[g*3 +: 3]);
        end
        // card transfer clock toggles once per sampling period
        @(negedge sys_clk);
        check(half, tick_cnt[0]);
        // second reset mutes and restores the reference source
        @(posedge sys_clk);
        resetn <= 1'b0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        check({en, mux}, 32'h0);
        @(posedge sys_clk);
        resetn <= 1'b1;
        wait_run;
        check(mux, use_local_osc);
        stop_test;
    end
endmodule // sampling_clock_source_test
`default_nettype wire
